// file: design/pilm_top.sv
// Module: peripheral interrupt flags, line controller and register port
//
// Function
// - Controller takes 32 lines, each with one of four priority levels.
// - Lines 0..25 except line 7 each fed by one peripheral; others have no source.
// - A peripheral sets its flag bit when its interrupt condition occurs.
// - Writing one to enable-set enables that source; zeros leave others alone.
// - Writing one to enable-clear disables that source without read-modify-write.
// - A peripheral requests only while a flag is set and also enabled.
// - All enabled requests of one peripheral are ORed into one line.
// - A request sets the pending bit; software may set or clear it too.
// - A pending line is activated only when its line enable is set.
// - Every line has a programmable priority field across eight registers.
// - Lines 0..8 map to fixed system peripherals, line 7 reserved.
// - Six serial interfaces drive lines 9 to 14 in instance order.
// - Control timers 15-17, basic timers 18-22, converter line 23.
// - The non-maskable output goes to the core NMI, not a line.
// - Controller registers decode from the fixed processor-private base.
// - Comparator line 24, digital-to-analog line 25, lines 26 and 27 reserved.
`timescale 1ns/10ps
module pilm_top #(
  parameter int FLAG_W = pilm_pkg::FLAG_W_DEF
) (
  input  wire logic                              core_clk_i,
  input  wire logic                              reset_n_i,
  input  wire logic                              ce_i,
  input  wire pilm_pkg::pilm_bus_req_t           bus_i,
  output logic [31:0]                            rdata_o,
  input  wire logic [pilm_pkg::NUM_LINES-1:0][FLAG_W-1:0] flag_evt_i,
  input  wire logic                              nmi_evt_i,
  output logic [pilm_pkg::NUM_LINES-1:0]         core_irq_o,
  output logic                                   core_nmi_o,
  output pilm_pkg::pilm_active_t                 active_o,
  output logic                                   irq_o
);
  import pilm_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  if (FLAG_W < 1 || FLAG_W > 32) begin : g_bad_flag_w
    $error("FLAG_W must be 1..32");
  end

  // ****************************************
  // Source map
  // ****************************************
  // Lines with a peripheral behind them; the rest stay silent
  function automatic logic [NUM_LINES-1:0] src_mask();
    logic [NUM_LINES-1:0] m;
    m = '0;
    m[LINE_POWER_MANAGER]   = 1'b1;
    m[LINE_SYSTEM_CONTROL]  = 1'b1;
    m[LINE_WATCHDOG]        = 1'b1;
    m[LINE_REAL_TIME_CNT]   = 1'b1;
    m[LINE_EXTERNAL_IRQ]    = 1'b1;
    m[LINE_NONVOLATILE_MEM] = 1'b1;
    m[LINE_MEMORY_ACCESS]   = 1'b1;
    m[LINE_EVENT_SYSTEM]    = 1'b1;
    for (int k = 0; k < NUM_SERIAL_IF; k++) begin
      m[LINE_SERIAL_IF_0 + k] = 1'b1;
    end
    for (int k = 0; k < NUM_CONTROL_TIMER; k++) begin
      m[LINE_CONTROL_TIMER_0 + k] = 1'b1;
    end
    for (int k = 0; k < NUM_BASIC_TIMER; k++) begin
      m[LINE_BASIC_TIMER_3 + k] = 1'b1;
    end
    m[LINE_ANALOG_TO_DIGITAL] = 1'b1;
    m[LINE_ANALOG_COMPARATOR] = 1'b1;
    m[LINE_DIGITAL_TO_ANALOG] = 1'b1;
    return m;
  endfunction

  localparam logic [NUM_LINES-1:0] SRC_MASK = src_mask();

  // ****************************************
  // Address decode
  // ****************************************
  logic        ctrl_hit;
  logic        per_hit;
  logic        evt_hit;
  logic [11:0] ctrl_ofs;
  logic [4:0]  per_line;
  logic [7:0]  per_ofs;
  logic        wr_en_set;
  logic        wr_en_clr;
  logic        wr_pend_set;
  logic        wr_pend_clr;
  logic        wr_prio;
  logic [2:0]  prio_idx;
  logic        rd_stat;

  // Controller window is the aligned 4 KB page that holds its base
  assign ctrl_hit    = (bus_i.addr[31:12] == CTRL_BASE[31:12]);
  assign ctrl_ofs    = bus_i.addr[11:0] - CTRL_BASE[11:0];
  assign per_hit     = (bus_i.addr[31:13] == PER_BASE[31:13]);
  assign per_line    = bus_i.addr[12:8];
  assign per_ofs     = bus_i.addr[7:0];
  assign evt_hit     = (bus_i.addr[31:4] == EVT_BASE[31:4]);
  assign wr_en_set   = bus_i.wr && ctrl_hit && ctrl_ofs == OFS_LINE_EN_SET;
  assign wr_en_clr   = bus_i.wr && ctrl_hit && ctrl_ofs == OFS_LINE_EN_CLR;
  assign wr_pend_set = bus_i.wr && ctrl_hit && ctrl_ofs == OFS_PEND_SET;
  assign wr_pend_clr = bus_i.wr && ctrl_hit && ctrl_ofs == OFS_PEND_CLR;
  assign wr_prio     = bus_i.wr && ctrl_hit && ctrl_ofs[11:5] == OFS_PRIO_BASE[11:5]
                       && ctrl_ofs[1:0] == 2'b00;
  assign prio_idx    = ctrl_ofs[4:2];
  assign rd_stat     = bus_i.rd && evt_hit && bus_i.addr[3:0] == OFS_EVT_STAT;

  // ****************************************
  // Peripheral flags and enables, per line
  // ****************************************
  logic [FLAG_W-1:0]    flag_r   [NUM_LINES];
  logic [FLAG_W-1:0]    flag_nxt [NUM_LINES];
  logic [FLAG_W-1:0]    en_r     [NUM_LINES];
  logic [FLAG_W-1:0]    en_nxt   [NUM_LINES];
  logic [NUM_LINES-1:0] req;
  logic [NUM_LINES-1:0] pend_r;
  logic [NUM_LINES-1:0] pend_nxt;
  logic [NUM_LINES-1:0] line_en_r;
  logic [NUM_LINES-1:0] line_en_nxt;

  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    logic              sel;
    logic [FLAG_W-1:0] fclr;
    assign sel  = bus_i.wr && per_hit && per_line == 5'(i) && SRC_MASK[i];
    assign fclr = (sel && per_ofs == OFS_FLAG) ? bus_i.wdata[FLAG_W-1:0] : '0;
    if (SRC_MASK[i]) begin : g_src
      // Event wins over a write-one-to-clear in the same cycle
      assign flag_nxt[i] = (flag_r[i] & ~fclr) | flag_evt_i[i];
      // Set and clear locations touch only the ones written
      assign en_nxt[i]   = (sel && per_ofs == OFS_EN_SET) ? (en_r[i] | bus_i.wdata[FLAG_W-1:0]) :
                           (sel && per_ofs == OFS_EN_CLR) ? (en_r[i] & ~bus_i.wdata[FLAG_W-1:0]) :
                           en_r[i];
      // Level request: any flag that is also enabled
      assign req[i]      = |(flag_r[i] & en_r[i]);
    end else begin : g_none
      // Reserved and unwired lines have no peripheral behind them
      assign flag_nxt[i] = '0;
      assign en_nxt[i]   = '0;
      assign req[i]      = 1'b0;
    end
    // Hardware request wins over a software clear
    assign pend_nxt[i]    = (pend_r[i] & ~(wr_pend_clr & bus_i.wdata[i]))
                            | (wr_pend_set & bus_i.wdata[i]) | req[i];
    assign line_en_nxt[i] = (wr_en_set && bus_i.wdata[i]) ? 1'b1 :
                            (wr_en_clr && bus_i.wdata[i]) ? 1'b0 : line_en_r[i];
  end

  // Flag and enable storage
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_LINES; i++) begin
      if (!reset_n_i) begin
        flag_r[i] <= '0;
        en_r[i]   <= '0;
      end else if (ce_i) begin
        flag_r[i] <= flag_nxt[i];
        en_r[i]   <= en_nxt[i];
      end
    end
  end

  // ****************************************
  // Controller state
  // ****************************************
  logic [PRIO_W-1:0] prio_r [NUM_LINES];

  // Pending and enable vectors
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pend_r    <= RST_WORD;
      line_en_r <= RST_WORD;
    end else if (ce_i) begin
      pend_r    <= pend_nxt;
      line_en_r <= line_en_nxt;
    end
  end

  // Priority fields, four per word, upper two bits of each byte
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_LINES; i++) begin
      if (!reset_n_i) begin
        prio_r[i] <= '0;
      end else if (ce_i && wr_prio && prio_idx == 3'(i / PRIO_PER_W)) begin
        prio_r[i] <= bus_i.wdata[(i % PRIO_PER_W) * 8 + PRIO_MSB -: PRIO_W];
      end
    end
  end

  // ****************************************
  // Core side
  // ****************************************
  pilm_active_t win;

  // Lowest field value wins; ties go to the lower line
  always_comb begin
    win = '0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (pend_r[i] && line_en_r[i] && (!win.valid || prio_r[i] <= win.prio)) begin
        win.valid = 1'b1;
        win.line  = 5'(i);
        win.prio  = prio_r[i];
      end
    end
  end

  // Registered view towards the core
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      core_irq_o <= '0;
      core_nmi_o <= 1'b0;
      active_o   <= '0;
    end else if (ce_i) begin
      core_irq_o <= pend_nxt & line_en_nxt;
      core_nmi_o <= nmi_evt_i;
      active_o   <= win;
    end
  end

  // ****************************************
  // Event status and interrupt
  // ****************************************
  logic [NUM_LINES-1:0] stat_r;
  logic [NUM_LINES-1:0] mask_r;
  logic [NUM_LINES-1:0] pend_rise;

  assign pend_rise = pend_nxt & ~pend_r;

  // Sticky on new pending; a read clears, but a new event in that cycle survives
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      stat_r <= RST_WORD;
    end else if (ce_i) begin
      stat_r <= (rd_stat ? '0 : stat_r) | pend_rise;
    end
  end

  // Mask register
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      mask_r <= RST_WORD;
    end else if (ce_i && bus_i.wr && evt_hit && bus_i.addr[3:0] == OFS_EVT_MASK) begin
      mask_r <= bus_i.wdata;
    end
  end

  assign irq_o = |(stat_r & mask_r);

  // ****************************************
  // Read path
  // ****************************************
  logic [31:0] rd_val;

  // Unmapped addresses read as zero
  always_comb begin
    rd_val = '0;
    if (ctrl_hit) begin
      if (ctrl_ofs == OFS_LINE_EN_SET || ctrl_ofs == OFS_LINE_EN_CLR) begin
        rd_val = line_en_r;
      end else if (ctrl_ofs == OFS_PEND_SET || ctrl_ofs == OFS_PEND_CLR) begin
        rd_val = pend_r;
      end else if (ctrl_ofs[11:5] == OFS_PRIO_BASE[11:5] && ctrl_ofs[1:0] == 2'b00) begin
        for (int b = 0; b < PRIO_PER_W; b++) begin
          rd_val[b * 8 + PRIO_MSB -: PRIO_W] = prio_r[{prio_idx, 2'(b)}];
        end
      end
    end else if (per_hit && SRC_MASK[per_line]) begin
      if (per_ofs == OFS_EN_SET || per_ofs == OFS_EN_CLR) begin
        rd_val[FLAG_W-1:0] = en_r[per_line];
      end else if (per_ofs == OFS_FLAG) begin
        rd_val[FLAG_W-1:0] = flag_r[per_line];
      end
    end else if (evt_hit) begin
      if (bus_i.addr[3:0] == OFS_EVT_STAT) begin
        rd_val = stat_r;
      end else if (bus_i.addr[3:0] == OFS_EVT_MASK) begin
        rd_val = mask_r;
      end
    end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= bus_i.rd ? rd_val : '0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Per-line rules watch a single line to keep the tools fast; reset gates every check

  property p_line_en_clear;
    ce_i && wr_en_clr |=> (line_en_r & $past(bus_i.wdata)) == '0 && (core_irq_o & $past(bus_i.wdata)) == '0;
  endproperty
  a_line_en_clear: assert property (p_line_en_clear) else $error("line enable clear not honoured");

  property p_en_set;
    ce_i && per_hit && bus_i.wr && per_ofs == OFS_EN_SET && per_line == 5'(LINE_WATCHDOG)
      |=> en_r[LINE_WATCHDOG] == ($past(en_r[LINE_WATCHDOG]) | $past(bus_i.wdata[FLAG_W-1:0]));
  endproperty
  a_en_set: assert property (p_en_set) else $error("enable set disturbed other bits");

  property p_en_clr;
    ce_i && per_hit && bus_i.wr && per_ofs == OFS_EN_CLR && per_line == 5'(LINE_WATCHDOG)
      |=> en_r[LINE_WATCHDOG] == ($past(en_r[LINE_WATCHDOG]) & ~$past(bus_i.wdata[FLAG_W-1:0]));
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("enable clear wrong");

  property p_flag_set;
    ce_i && flag_evt_i[LINE_POWER_MANAGER] != '0
      |=> (flag_r[LINE_POWER_MANAGER] & $past(flag_evt_i[LINE_POWER_MANAGER])) == $past(flag_evt_i[LINE_POWER_MANAGER]);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

  property p_req_pend;
    ce_i && req[LINE_SERIAL_IF_0] |=> pend_r[LINE_SERIAL_IF_0];
  endproperty
  a_req_pend: assert property (p_req_pend) else $error("request did not hold pending");

  property p_reserved_quiet;
    $rose(pend_r[LINE_RESERVED_A]) |-> $past(wr_pend_set && bus_i.wdata[LINE_RESERVED_A]);
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved line went pending by itself");

  property p_nmi;
    ce_i && nmi_evt_i |=> core_nmi_o;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not forwarded");

  property p_prio_store;
    ce_i && wr_prio && prio_idx == 3'd2 |=> prio_r[LINE_SERIAL_IF_0] == $past(bus_i.wdata[15:14]);
  endproperty
  a_prio_store: assert property (p_prio_store) else $error("priority field not stored");

  property p_read_en;
    ce_i && bus_i.rd && ctrl_hit && ctrl_ofs == OFS_LINE_EN_SET |=> rdata_o == $past(line_en_r);
  endproperty
  a_read_en: assert property (p_read_en) else $error("enable readback wrong");

  property p_stat_clear;
    ce_i && rd_stat && pend_rise == '0 |=> stat_r == '0 ##1 1'b1;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

  // A line that goes pending must land in the sticky status
  property p_stat_sticky;
    ce_i && pend_rise != '0 |=> (stat_r & $past(pend_rise)) == $past(pend_rise);
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status missed a new pending line");

  // Read data may not linger; a stale word would look like a second read
  property p_rd_idle;
    ce_i && !bus_i.rd |=> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  // Something is offered to the core exactly when a line is pending and enabled
  property p_active_valid;
    ce_i |=> active_o.valid == $past(|(pend_r & line_en_r));
  endproperty
  a_active_valid: assert property (p_active_valid) else $error("active line without enabled pending");

  // Software clear sticks once the peripheral request has gone
  property p_pend_clr;
    ce_i && wr_pend_clr && bus_i.wdata[LINE_EXTERNAL_IRQ] && !req[LINE_EXTERNAL_IRQ]
      |=> !pend_r[LINE_EXTERNAL_IRQ];
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending clear not honoured");

  // Main scenarios worth seeing in a run
  c_pend_active:  cover property (ce_i && req[LINE_EXTERNAL_IRQ] ##[1:4] core_irq_o[LINE_EXTERNAL_IRQ]);
  c_irq_raised:   cover property (!irq_o ##1 irq_o);
  c_prio_win:     cover property (active_o.valid && active_o.prio == 2'd0 && active_o.line != 5'd0);
  c_evt_on_clear: cover property (ce_i && rd_stat && pend_rise != '0);
  c_ce_frozen:    cover property (!ce_i && bus_i.wr);

endmodule

// file: design/pilm_pkg.sv
// Package: constants and carrier types for the peripheral interrupt line mapper
package pilm_pkg;

  // ****************************************
  // Controller geometry
  // ****************************************
  localparam int          NUM_LINES  = 32;
  localparam int          PRIO_W     = 2;
  localparam int          PRIO_MSB   = 7;           // Priority field sits in the top of each byte
  localparam int          PRIO_PER_W = 4;           // Fields per priority register
  localparam int          NUM_PRIO_R = 8;
  localparam int          FLAG_W_DEF = 8;

  // ****************************************
  // Line assignment
  // ****************************************
  localparam int          LINE_POWER_MANAGER    = 0;
  localparam int          LINE_SYSTEM_CONTROL   = 1;
  localparam int          LINE_WATCHDOG         = 2;
  localparam int          LINE_REAL_TIME_CNT    = 3;
  localparam int          LINE_EXTERNAL_IRQ     = 4;
  localparam int          LINE_NONVOLATILE_MEM  = 5;
  localparam int          LINE_MEMORY_ACCESS    = 6;
  localparam int          LINE_RESERVED_A       = 7;
  localparam int          LINE_EVENT_SYSTEM     = 8;
  localparam int          LINE_SERIAL_IF_0      = 9;
  localparam int          NUM_SERIAL_IF         = 6;
  localparam int          LINE_CONTROL_TIMER_0  = 15;
  localparam int          NUM_CONTROL_TIMER     = 3;
  localparam int          LINE_BASIC_TIMER_3    = 18;
  localparam int          NUM_BASIC_TIMER       = 5;
  localparam int          LINE_ANALOG_TO_DIGITAL = 23;
  localparam int          LINE_ANALOG_COMPARATOR = 24;
  localparam int          LINE_DIGITAL_TO_ANALOG = 25;
  localparam int          NUM_WIRED_LINES       = 28;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] CTRL_BASE      = 32'hE000_E100;
  localparam logic [11:0] OFS_LINE_EN_SET = 12'h000;
  localparam logic [11:0] OFS_LINE_EN_CLR = 12'h080;
  localparam logic [11:0] OFS_PEND_SET    = 12'h100;
  localparam logic [11:0] OFS_PEND_CLR    = 12'h180;
  localparam logic [11:0] OFS_PRIO_BASE   = 12'h300;
  localparam logic [31:0] PER_BASE       = 32'h4000_0000;   // 0x100 per line, line in addr[12:8]
  localparam logic [7:0]  OFS_EN_CLR      = 8'h00;
  localparam logic [7:0]  OFS_EN_SET      = 8'h04;
  localparam logic [7:0]  OFS_FLAG        = 8'h08;
  localparam logic [31:0] EVT_BASE       = 32'h4000_4000;
  localparam logic [3:0]  OFS_EVT_STAT    = 4'h0;
  localparam logic [3:0]  OFS_EVT_MASK    = 4'h4;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;

  // Register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pilm_bus_req_t;

  // Winning line towards the core
  typedef struct packed {
    logic        valid;
    logic [4:0]  line;
    logic [1:0]  prio;
  } pilm_active_t;

endpackage

// file: dv/pilm_periph_model.sv
// Partner model: peripheral interrupt sources and the non-maskable source
`timescale 1ns/10ps
module pilm_periph_model #(
  parameter int FLAG_W = 8
) (
  input  wire logic                                  fire_i,
  input  wire logic [4:0]                            line_i,
  input  wire logic [FLAG_W-1:0]                     mask_i,
  input  wire logic                                  nmi_i,
  output logic [pilm_pkg::NUM_LINES-1:0][FLAG_W-1:0] flag_evt_o,
  output logic                                       nmi_evt_o
);
  import pilm_pkg::*;

  // ****************************************
  // Event sources
  // ****************************************
  // Conditions arise as one-cycle strobes of the chosen flags; idle is all zero
  always_comb begin
    flag_evt_o = '0;
    if (fire_i) begin
      flag_evt_o[line_i] = mask_i;
    end
  end

  // Non-maskable source has its own wire, never a numbered line
  assign nmi_evt_o = nmi_i;
endmodule

// file: dv/testbench.sv
// Testbench: line mapper driven through its register port and partner model
`timescale 1ns/10ps
module testbench;
  import pilm_pkg::*;

  localparam int          FW    = 8;
  localparam logic [31:0] A_LES = CTRL_BASE + 32'(OFS_LINE_EN_SET);
  localparam logic [31:0] A_LEC = CTRL_BASE + 32'(OFS_LINE_EN_CLR);
  localparam logic [31:0] A_PS  = CTRL_BASE + 32'(OFS_PEND_SET);
  localparam logic [31:0] A_PC  = CTRL_BASE + 32'(OFS_PEND_CLR);
  localparam logic [31:0] A_PR  = CTRL_BASE + 32'(OFS_PRIO_BASE);

  logic                          core_clk_i = 1'b0;
  logic                          reset_n_i  = 1'b0;
  logic                          ce_i       = 1'b1;
  pilm_bus_req_t                 bus        = '0;
  logic [31:0]                   rdata_o;
  logic                          ev_fire    = 1'b0;
  logic [4:0]                    ev_line    = '0;
  logic [FW-1:0]                 ev_mask    = '0;
  logic                          nmi_req    = 1'b0;
  logic [NUM_LINES-1:0][FW-1:0]  flag_evt;
  logic                          nmi_evt;
  logic [NUM_LINES-1:0]          core_irq_o;
  logic                          core_nmi_o;
  pilm_active_t                  active_o;
  logic                          irq_o;
  int                            n_mismatch = 0;
  int                            compares   = 0;
  int                            seed       = 32'h4f65_e03e;
  int                            m_en[NUM_LINES];
  int                            m_flag[NUM_LINES];
  logic [31:0]                   m_pend     = '0;
  logic [31:0]                   m_len      = '0;
  logic [31:0]                   a;
  logic [31:0]                   d;
  int                            b;
  int                            p9;
  int                            p20;
  int                            win;

  always #2.5 core_clk_i = ~core_clk_i;

  pilm_top #(.FLAG_W(FW)) uut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .bus_i(bus), .rdata_o(rdata_o),
    .flag_evt_i(flag_evt), .nmi_evt_i(nmi_evt), .core_irq_o(core_irq_o), .core_nmi_o(core_nmi_o),
    .active_o(active_o), .irq_o(irq_o)
  );

  pilm_periph_model #(.FLAG_W(FW)) u_periph (
    .fire_i(ev_fire), .line_i(ev_line), .mask_i(ev_mask), .nmi_i(nmi_req),
    .flag_evt_o(flag_evt), .nmi_evt_o(nmi_evt)
  );

  // ****************************************
  // Model helpers and bus tasks
  // ****************************************
  // Lines that carry a peripheral source
  function automatic bit wired(input int l);
    return (l < NUM_WIRED_LINES) && (l != LINE_RESERVED_A) && (l != 26) && (l != 27);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [31:0] ad, input logic [31:0] dt);
    @(posedge core_clk_i);
    bus.addr  <= ad;
    bus.wdata <= dt;
    bus.wr    <= 1'b1;
    @(posedge core_clk_i);
    bus.wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic chkrd(input string nm, input logic [31:0] ad, input logic [31:0] exp);
    @(posedge core_clk_i);
    bus.addr <= ad;
    bus.rd   <= 1'b1;
    @(posedge core_clk_i);
    bus.rd   <= 1'b0;
    #1;
    d = rdata_o;
    chk(nm, d, exp);
  endtask

  // Flag event, then wait until pending has landed
  task automatic ev(input int l, input int m);
    @(posedge core_clk_i);
    ev_fire <= 1'b1;
    ev_line <= l[4:0];
    ev_mask <= m[FW-1:0];
    @(posedge core_clk_i);
    ev_fire <= 1'b0;
    @(posedge core_clk_i);
    #1;
    if (wired(l)) m_flag[l] |= m;
    if ((m_flag[l] & m_en[l]) != 0) m_pend[l] = 1'b1;
  endtask

  // Software pending clear; a live request keeps the line pending
  task automatic pclr(input int l);
    wr(A_PC, 32'h0000_0001 << l);
    #1;
    m_pend[l] = (m_flag[l] & m_en[l]) != 0;
  endtask

  // Hang guard: bounded run length
  initial begin
    repeat (100000) @(posedge core_clk_i);
    n_mismatch++;
    tally_and_finish();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    foreach (m_en[i]) m_en[i] = 0;
    foreach (m_flag[i]) m_flag[i] = 0;
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk("rst_core_irq", core_irq_o, 32'h0000_0000);
    chk("rst_act", 32'(active_o.valid), 32'h0000_0000);
    chk("rst_irq", 32'(irq_o), 32'h0000_0000);
    chkrd("rst_len", A_LES, 32'h0000_0000);
    wr(A_LES, 32'hffff_ffff);
    m_len = '1;
    // Walk every line: mapping, enables, flags, OR and level behaviour
    for (int l = 0; l < NUM_LINES; l++) begin
      a = PER_BASE + 32'(l) * 32'h0000_0100;
      b = $unsigned($random(seed)) % 7;
      wr(a + 32'h4, 32'h0000_0005);
      wr(a + 32'h4, 32'h0000_00fa);
      chkrd("per_en_set", a + 32'h4, wired(l) ? 32'h0000_00ff : 32'h0000_0000);
      wr(a, 32'h0000_0001);
      m_en[l] = wired(l) ? 254 : 0;
      chkrd("per_en_clr", a, m_en[l]);
      ev(l, 1);
      chk("irq_disabled_flag", core_irq_o, m_pend & m_len);
      ev(l, 3 << b);
      chk("irq_line_map", core_irq_o, m_pend & m_len);
      chkrd("flags", a + 32'h8, m_flag[l]);
      pclr(l);
      chk("irq_level_held", core_irq_o, m_pend & m_len);
      for (int j = 0; j < FW; j++) begin
        if (m_flag[l][j]) begin
          wr(a + 32'h8, 32'h0000_0001 << j);
          m_flag[l][j] = 1'b0;
          pclr(l);
          chk("irq_or_drop", core_irq_o, m_pend & m_len);
        end
      end
    end
    // Priority fields and arbitration, ties included
    repeat (4) begin
      p9 = $unsigned($random(seed)) % 4;
      p20 = $unsigned($random(seed)) % 4;
      wr(A_PR + 32'h8, 32'(p9) << 14);
      wr(A_PR + 32'h14, 32'(p20) << 6);
      chkrd("prio_rd", A_PR + 32'h8, 32'(p9) << 14);
      wr(A_PS, 32'h0010_0200);
      m_pend = m_pend | 32'h0010_0200;
      repeat (2) @(posedge core_clk_i);
      #1;
      win = (p9 <= p20) ? 9 : 20;
      chk("act_valid", 32'(active_o.valid), 32'h0000_0001);
      chk("act_line", 32'(active_o.line), win);
      chk("act_prio", 32'(active_o.prio), (win == 9) ? p9 : p20);
      chkrd("pend_rd", A_PS, m_pend);
      wr(A_PC, 32'h0010_0200);
      m_pend = m_pend & ~32'h0010_0200;
    end
    // Status gathers every line that went pending; mask gates the output
    chkrd("status_all", EVT_BASE, 32'h03ff_ff7f);
    wr(EVT_BASE + 32'h4, 32'h0000_0008);
    wr(A_PS, 32'h0000_0020);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("irq_masked", 32'(irq_o), 32'h0000_0000);
    wr(A_PS, 32'h0000_0008);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("irq_unmasked", 32'(irq_o), 32'h0000_0001);
    chkrd("status", EVT_BASE, 32'h0000_0028);
    chk("irq_after_read", 32'(irq_o), 32'h0000_0000);
    wr(A_PC, 32'h0000_0028);
    // Pending line stays inactive while its line enable is clear
    wr(A_LEC, 32'h0000_0200);
    m_len[9] = 1'b0;
    chkrd("len_rd", A_LES, m_len);
    wr(A_PS, 32'h0000_0200);
    #1;
    m_pend[9] = 1'b1;
    chk("irq_line_off", core_irq_o, m_pend & m_len);
    wr(A_LES, 32'h0000_0200);
    #1;
    m_len[9] = 1'b1;
    chk("irq_line_back", core_irq_o, m_pend & m_len);
    pclr(9);
    // Frozen clock enable drops a write
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    wr(A_PS, 32'h0000_0010);
    ce_i <= 1'b1;
    chkrd("ce_frozen", A_PS, m_pend);
    // Non-maskable source reaches its own output only
    @(posedge core_clk_i);
    nmi_req <= 1'b1;
    @(posedge core_clk_i);
    nmi_req <= 1'b0;
    #1;
    chk("nmi_out", 32'(core_nmi_o), 32'h0000_0001);
    chk("nmi_no_line", core_irq_o, m_pend & m_len);
    @(posedge core_clk_i);
    #1;
    chk("nmi_drop", 32'(core_nmi_o), 32'h0000_0000);
    // Mid-run reset clears the line enables
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    m_len = '0;
    chkrd("rst_mid_len", A_LES, m_len);
    // Addresses outside the decoded windows read zero and ignore writes
    wr(32'h1000_0000, 32'hffff_ffff);
    chkrd("unmapped", 32'h1000_0000, 32'h0000_0000);
    chkrd("alias", 32'he001_e100, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
